// ---- hdl/gpm_pkg.sv ----
/*
  Shared constants and types for the two-pin function multiplexer:
  register word indices, field positions, reset values,
  function codes, bus answers and the carrier structs.
  Assumes a 32-bit AXI4-Lite register bus with word-aligned registers.
*/
package gpm_pkg;

  // ==========================================================
  // Bus geometry and register map
  // ==========================================================
  localparam int unsigned  ADDR_W       = 12;
  localparam int unsigned  DATA_W       = 32;
  localparam logic [9:0]   PIN2_INDEX   = 10'h201;
  localparam logic [9:0]   PIN3_INDEX   = 10'h202;
  localparam logic [1:0]   RESP_OKAY    = 2'h0;
  localparam logic [1:0]   RESP_SLVERR  = 2'h2;

  // ==========================================================
  // Field layout of a pin control register
  // ==========================================================
  localparam int unsigned  INVERT_BIT   = 10;
  localparam int unsigned  LEVEL_BIT    = 6;
  localparam int unsigned  SEL_LSB      = 0;
  localparam int unsigned  SEL_W        = 5;
  localparam logic         INVERT_RESET = 1'h0;
  localparam logic         LEVEL_RESET  = 1'h0;

  // ==========================================================
  // Function codes
  // ==========================================================
  typedef enum logic [4:0] {
    FN_CLOCK      = 5'h00,
    FN_LEVEL      = 5'h01,
    FN_SERIAL_OUT = 5'h02,
    FN_IRQ        = 5'h03,
    FN_TEMP_SHUT  = 5'h04,
    FN_RSVD_05    = 5'h05,
    FN_LOCK_2     = 5'h06,
    FN_LOCK_3     = 5'h07,
    FN_RSVD_08    = 5'h08,
    FN_LOCK_FREQ  = 5'h09,
    FN_DRC_ACTIVE = 5'h0a,
    FN_SEQ_DONE   = 5'h0b,
    FN_ALC_GATE   = 5'h0c,
    FN_ALC_LIMIT  = 5'h0d,
    FN_ALC_SAT    = 5'h0e,
    FN_ALC_THRESH = 5'h0f,
    FN_ALC_LOCK   = 5'h10,
    FN_FIFO_ERR   = 5'h11,
    FN_AUX_CLOCK  = 5'h12,
    FN_MIC_CLOCK  = 5'h13,
    FN_RSVD_14    = 5'h14,
    FN_MIC_DETECT = 5'h15,
    FN_MIC_SHORT  = 5'h16
  } gpm_func_type;

  localparam gpm_func_type SEL_RESET    = FN_CLOCK;

  // ==========================================================
  // Carriers
  // ==========================================================
  typedef struct packed {
    logic invert;
    logic sw_level;
    gpm_func_type select;
  } gpm_pin_ctrl_type;

  typedef struct packed {
    logic serial_audio_data_out;
    logic irq;
    logic temp_shutdown;
    logic second_phase_loop_lock;
    logic third_phase_loop_lock;
    logic frequency_locked_loop_lock;
    logic dynamic_range_control_active;
    logic write_sequencer_done;
    logic auto_level_control_gate;
    logic auto_level_control_limit;
    logic auto_level_control_saturation;
    logic auto_level_control_threshold;
    logic auto_level_control_lock;
    logic fifo_error;
    logic auxiliary_output_clock;
    logic mic_output_clock;
    logic mic_detect;
    logic mic_short;
  } gpm_sources_type;

endpackage : gpm_pkg

// ---- hdl/gpm_pin_mux.sv ----
/*
  One pin's source selector with polarity and an output flip-flop.
  Assumes every source, including the clocks, is synchronous to clk
  and that the control word comes from flip-flops.
*/
`timescale 1ns/10ps
`default_nettype none

module gpm_pin_mux (
  // Clock and reset
  input  wire logic                      clk,
  input  wire logic                      resetn,
  // Control and sources
  input  wire gpm_pkg::gpm_pin_ctrl_type ctrl,
  input  wire gpm_pkg::gpm_sources_type  sources,
  input  wire logic                      clock_in,
  // Pin
  output logic                           pin_out
);
  import gpm_pkg::*;

  // ==========================================================
  // Selection
  // ==========================================================
  // Reserved codes give a quiet low before polarity.
  // Every input is an argument, so the continuous assignment wakes
  // on a change of the software level alone as well.
  function automatic logic pick(input gpm_func_type f,
                                input logic lvl,
                                input gpm_sources_type s,
                                input logic c);
    case (f)
      FN_CLOCK:      pick = c;
      FN_LEVEL:      pick = lvl;                            // R2
      FN_SERIAL_OUT: pick = s.serial_audio_data_out;        // R7
      FN_IRQ:        pick = s.irq;                          // R7
      FN_TEMP_SHUT:  pick = s.temp_shutdown;                // R7
      FN_LOCK_2:     pick = s.second_phase_loop_lock;       // R8
      FN_LOCK_3:     pick = s.third_phase_loop_lock;        // R8
      FN_LOCK_FREQ:  pick = s.frequency_locked_loop_lock;   // R8
      FN_DRC_ACTIVE: pick = s.dynamic_range_control_active; // R8
      FN_SEQ_DONE:   pick = s.write_sequencer_done;         // R9
      FN_ALC_GATE:   pick = s.auto_level_control_gate;      // R9
      FN_ALC_LIMIT:  pick = s.auto_level_control_limit;     // R10
      FN_ALC_SAT:    pick = s.auto_level_control_saturation; // R10
      FN_ALC_THRESH: pick = s.auto_level_control_threshold; // R11
      FN_ALC_LOCK:   pick = s.auto_level_control_lock;      // R11
      FN_FIFO_ERR:   pick = s.fifo_error;                   // R12
      FN_AUX_CLOCK:  pick = s.auxiliary_output_clock;       // R12
      FN_MIC_CLOCK:  pick = s.mic_output_clock;             // R12
      FN_MIC_DETECT: pick = s.mic_detect;                   // R13
      FN_MIC_SHORT:  pick = s.mic_short;                    // R13
      default:       pick = 1'b0;                           // R14
    endcase
  endfunction

  wire logic selected;
  wire logic next_pin;

  assign selected = pick(ctrl.select, ctrl.sw_level, sources, clock_in);
  // Inversion sits after the selector so it covers every source.
  assign next_pin = selected ^ ctrl.invert;                 // R1 R18

  // The flop keeps selector changes from showing decode hazards.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pin_out <= 1'b0;
    end else begin
      pin_out <= next_pin;                                  // R19
    end
  end

  // ==========================================================
  // Checks
  // ==========================================================
  chk_level_drive: assert property (@(posedge clk) disable iff (!resetn) // R2
    ctrl.select == FN_LEVEL |=>
      pin_out == ($past(ctrl.sw_level) ^ $past(ctrl.invert)))
    else $error("pin does not follow the software level");

  chk_irq_route: assert property (@(posedge clk) disable iff (!resetn) // R7
    ctrl.select == FN_IRQ && !ctrl.invert |=> pin_out == $past(sources.irq))
    else $error("pin does not carry the interrupt line");

  chk_invert_route: assert property (@(posedge clk) disable iff (!resetn) // R1
    ctrl.select == FN_MIC_SHORT && ctrl.invert |=>
      pin_out == !$past(sources.mic_short))
    else $error("inverted flag not seen on the pin");

  chk_reserved_quiet: assert property (@(posedge clk) // R14
    disable iff (!resetn)
    (ctrl.select inside {FN_RSVD_05, FN_RSVD_08, FN_RSVD_14} ||
     ctrl.select > FN_MIC_SHORT) |=>
      pin_out == $past(ctrl.invert))
    else $error("reserved code drives a live source");

  chk_clock_route: assert property (@(posedge clk) disable iff (!resetn) // R5
    ctrl.select == FN_CLOCK && !ctrl.invert |=> pin_out == $past(clock_in))
    else $error("clock source not on the pin");

endmodule : gpm_pin_mux

`default_nettype wire

// ---- hdl/gpm_top.sv ----
/*
  Two-pin function multiplexer with its AXI4-Lite register slave.
  Assumes an AXI4-Lite master with one write and one read in flight at
  most, and status sources that are synchronous to clk.
*/
// What this block does
// (R1) Polarity bit 10 set inverts the selected pin signal, clear passes it.
// (R2) Function code 00001 drives the pin to the level bit at bit 6.
// (R3) Level bit is write-only; its readback means nothing.
// (R4) Function selector occupies bits 4 to 0 and resets to zero.
// (R5) Pin 2 code zero carries the second loop or oscillator clock.
// (R6) Pin 3 code zero carries the third loop or frequency loop clock.
// (R7) Codes 2, 3, 4 give serial data out, interrupt, over-temperature.
// (R8) Codes 6, 7, 9, 10 give loop locks and range control activity.
// (R9) Code 11 gives sequencer done, code 12 level control noise gate.
// (R10) Code 13 gives limiter overload, code 14 level control saturation.
// (R11) Code 15 gives level threshold, code 16 level lock.
// (R12) Codes 17, 18, 19 give FIFO error, auxiliary and microphone clocks.
// (R13) Code 21 gives microphone detect, code 22 microphone short.
// (R14) Reserved codes must not be programmed by software.
// (R15) Software keeps pin 2 selector zero when its clock output is used.
// (R16) Software keeps pin 3 selector zero when its clock output is used.
// (R17) Pin 3 decodes codes 13 through 22 exactly like pin 2.
// (R18) Inversion acts after selection, including on the software level.
// (R19) Register writes reach the pin within a few cycles, glitch free.
`timescale 1ns/10ps
`default_nettype none

module gpm_top (
  // Clock and reset
  input  wire logic                         clk,
  input  wire logic                         resetn,
  // AXI4-Lite write address
  input  wire logic [gpm_pkg::ADDR_W-1:0]   s_axi_awaddr,
  input  wire logic                         s_axi_awvalid,
  output logic                              s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [gpm_pkg::DATA_W-1:0]   s_axi_wdata,
  input  wire logic [gpm_pkg::DATA_W/8-1:0] s_axi_wstrb,
  input  wire logic                         s_axi_wvalid,
  output logic                              s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]                        s_axi_bresp,
  output logic                              s_axi_bvalid,
  input  wire logic                         s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [gpm_pkg::ADDR_W-1:0]   s_axi_araddr,
  input  wire logic                         s_axi_arvalid,
  output logic                              s_axi_arready,
  // AXI4-Lite read data
  output logic [gpm_pkg::DATA_W-1:0]        s_axi_rdata,
  output logic [1:0]                        s_axi_rresp,
  output logic                              s_axi_rvalid,
  input  wire logic                         s_axi_rready,
  // Function sources
  input  wire gpm_pkg::gpm_sources_type     sources,
  input  wire logic                         pin2_clock_output,
  input  wire logic                         pin3_clock_output,
  // Pins
  output logic                              pin2_out,
  output logic                              pin3_out
);
  import gpm_pkg::*;

  // ==========================================================
  // Register helpers
  // ==========================================================
  localparam int unsigned STRB_INV = INVERT_BIT / 8;
  localparam int unsigned STRB_LOW = LEVEL_BIT / 8;

  // Byte lanes are honoured: the polarity bit lives in lane 1, the
  // level and selector in lane 0.
  function automatic gpm_pin_ctrl_type merge_ctrl(
      input gpm_pin_ctrl_type old,
      input logic [DATA_W-1:0] d,
      input logic [DATA_W/8-1:0] s);
    gpm_pin_ctrl_type r;
    r = old;
    if (s[STRB_INV]) begin
      r.invert = d[INVERT_BIT];
    end
    if (s[STRB_LOW]) begin
      r.sw_level = d[LEVEL_BIT];
      r.select   = gpm_func_type'(d[SEL_LSB +: SEL_W]);   // R4
    end
    return r;
  endfunction

  // The level bit is not returned, so software cannot lean on it.
  function automatic logic [DATA_W-1:0] view_ctrl(
      input gpm_pin_ctrl_type c);
    logic [DATA_W-1:0] v;
    v = '0;
    v[INVERT_BIT]        = c.invert;
    v[LEVEL_BIT]         = 1'b0;                           // R3
    v[SEL_LSB +: SEL_W]  = c.select;
    return v;
  endfunction

  // ==========================================================
  // Write channel
  // ==========================================================
  logic                  aw_held;
  logic [ADDR_W-1:0]     aw_addr;
  logic                  w_held;
  logic [DATA_W-1:0]     w_data;
  logic [DATA_W/8-1:0]   w_strb;
  gpm_pin_ctrl_type      pin2_ctrl;
  gpm_pin_ctrl_type      pin3_ctrl;

  wire logic                aw_take;
  wire logic                w_take;
  wire logic                wr_fire;
  wire logic [ADDR_W-1:0]   wr_addr;
  wire logic [DATA_W-1:0]   wr_data;
  wire logic [DATA_W/8-1:0] wr_strb;
  wire logic                wr_hit2;
  wire logic                wr_hit3;
  wire gpm_pin_ctrl_type    next_pin2_ctrl;
  wire gpm_pin_ctrl_type    next_pin3_ctrl;

  // No new address or data is taken while a response waits, which
  // keeps one write in flight and the skid logic trivial.
  assign s_axi_awready  = !aw_held && !s_axi_bvalid;
  assign s_axi_wready   = !w_held && !s_axi_bvalid;
  assign aw_take        = s_axi_awvalid && s_axi_awready;
  assign w_take         = s_axi_wvalid && s_axi_wready;
  assign wr_fire        = (aw_held || aw_take) && (w_held || w_take);
  assign wr_addr        = aw_held ? aw_addr : s_axi_awaddr;
  assign wr_data        = w_held ? w_data : s_axi_wdata;
  assign wr_strb        = w_held ? w_strb : s_axi_wstrb;
  assign wr_hit2        = wr_addr[ADDR_W-1:2] == PIN2_INDEX;
  assign wr_hit3        = wr_addr[ADDR_W-1:2] == PIN3_INDEX;
  assign next_pin2_ctrl = merge_ctrl(pin2_ctrl, wr_data, wr_strb);
  assign next_pin3_ctrl = merge_ctrl(pin3_ctrl, wr_data, wr_strb);

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      aw_held <= 1'b0;
      aw_addr <= '0;
    end else if (wr_fire) begin
      aw_held <= 1'b0;
    end else if (aw_take) begin
      aw_held <= 1'b1;
      aw_addr <= s_axi_awaddr;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      w_held <= 1'b0;
      w_data <= '0;
      w_strb <= '0;
    end else if (wr_fire) begin
      w_held <= 1'b0;
    end else if (w_take) begin
      w_held <= 1'b1;
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= (wr_hit2 || wr_hit3) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ==========================================================
  // Control registers
  // ==========================================================
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pin2_ctrl <= '{INVERT_RESET, LEVEL_RESET, SEL_RESET};  // R4
      pin3_ctrl <= '{INVERT_RESET, LEVEL_RESET, SEL_RESET};  // R4
    end else if (wr_fire) begin
      if (wr_hit2) begin
        pin2_ctrl <= next_pin2_ctrl;
      end
      if (wr_hit3) begin
        pin3_ctrl <= next_pin3_ctrl;
      end
    end
  end

  // ==========================================================
  // Read channel
  // ==========================================================
  wire logic              ar_take;
  wire logic              rd_hit2;
  wire logic              rd_hit3;
  wire logic [DATA_W-1:0] rd_word;

  assign s_axi_arready = !s_axi_rvalid;
  assign ar_take       = s_axi_arvalid && s_axi_arready;
  assign rd_hit2       = s_axi_araddr[ADDR_W-1:2] == PIN2_INDEX;
  assign rd_hit3       = s_axi_araddr[ADDR_W-1:2] == PIN3_INDEX;
  assign rd_word       = rd_hit2 ? view_ctrl(pin2_ctrl) :
                         rd_hit3 ? view_ctrl(pin3_ctrl) : '0;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= RESP_OKAY;
    end else if (ar_take) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_word;
      s_axi_rresp  <= (rd_hit2 || rd_hit3) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ==========================================================
  // Pin selectors
  // ==========================================================
  // Both pins use the same decoder module, so the upper codes match by build.
  gpm_pin_mux u_pin2 (
    .clk      (clk),
    .resetn   (resetn),
    .ctrl     (pin2_ctrl),
    .sources  (sources),
    .clock_in (pin2_clock_output),                          // R5
    .pin_out  (pin2_out)
  );

  gpm_pin_mux u_pin3 (                                      // R17
    .clk      (clk),
    .resetn   (resetn),
    .ctrl     (pin3_ctrl),
    .sources  (sources),
    .clock_in (pin3_clock_output),                          // R6
    .pin_out  (pin3_out)
  );

  // ==========================================================
  // Checks
  // ==========================================================
  chk_ctrl_write: assert property (@(posedge clk) disable iff (!resetn) // R19
    wr_fire && wr_hit2 && wr_strb[STRB_LOW] |=>
      pin2_ctrl.select == $past(wr_data[SEL_LSB +: SEL_W]))
    else $error("selector write not stored");

  chk_write_to_pin: assert property (@(posedge clk) disable iff (!resetn) // R19
    wr_fire && wr_hit3 && wr_strb[STRB_LOW] &&
    wr_data[SEL_LSB +: SEL_W] == FN_LEVEL ##1 pin3_ctrl.select == FN_LEVEL
    |=> pin3_out == (pin3_ctrl.sw_level ^ pin3_ctrl.invert))
    else $error("pin 3 level not on the pin two cycles after write");

  chk_level_hidden: assert property (@(posedge clk) disable iff (!resetn) // R3
    s_axi_rvalid |-> s_axi_rdata[LEVEL_BIT] == 1'b0)
    else $error("level bit returned on read");

  chk_select_readback: assert property (@(posedge clk) // R4
    disable iff (!resetn)
    ar_take && rd_hit3 |=>
      s_axi_rdata[SEL_LSB +: SEL_W] == $past(pin3_ctrl.select))
    else $error("selector readback wrong");

  chk_reset_select: assert property (@(posedge clk) // R4
    $rose(resetn) |-> pin2_ctrl.select == FN_CLOCK &&
      pin3_ctrl.select == FN_CLOCK)
    else $error("selector not zero after reset");

  chk_bresp_hold: assert property (@(posedge clk) disable iff (!resetn)
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");

  chk_rdata_hold: assert property (@(posedge clk) disable iff (!resetn)
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");

  chk_unmapped_err: assert property (@(posedge clk) disable iff (!resetn)
    wr_fire && !wr_hit2 && !wr_hit3 |=> s_axi_bresp == RESP_SLVERR)
    else $error("unmapped write not refused");

  // Pin 3 takes its own clock, never the one meant for pin 2.
  chk_pin3_clock: assert property (@(posedge clk) disable iff (!resetn) // R6
    pin3_ctrl.select == FN_CLOCK && !pin3_ctrl.invert |=>
      pin3_out == $past(pin3_clock_output))
    else $error("pin 3 clock source not on the pin");

  chk_level_inverted: assert property (@(posedge clk) // R18
    disable iff (!resetn)
    pin2_ctrl.select == FN_LEVEL && pin2_ctrl.invert |=>
      pin2_out == !$past(pin2_ctrl.sw_level))
    else $error("inverted software level not on pin 2");

  cov_write_pin2: cover property (@(posedge clk) disable iff (!resetn)
    wr_fire && wr_hit2);
  cov_read_pin3: cover property (@(posedge clk) disable iff (!resetn)
    ar_take && rd_hit3);
  cov_split_write: cover property (@(posedge clk) disable iff (!resetn)
    aw_take && !w_take ##[1:4] w_take);
  cov_inverted_level: cover property (@(posedge clk) disable iff (!resetn)
    pin2_ctrl.select == FN_LEVEL && pin2_ctrl.invert);
  cov_reserved_code: cover property (@(posedge clk) disable iff (!resetn)
    pin3_ctrl.select > FN_MIC_SHORT);

endmodule : gpm_top

`default_nettype wire

// ---- tb/gpm_pin_sampler.sv ----
/*
  Far-side model: logic that samples both pins on the register clock.
  Assumes the pins change only just after rising edges of clk.
*/
`timescale 1ns/10ps
`default_nettype none

module gpm_pin_sampler (
  // Clock and reset
  input  wire logic clk,
  input  wire logic resetn,
  // Pins
  input  wire logic pin2,
  input  wire logic pin3,
  // Sampled levels
  output logic      seen2,
  output logic      seen3
);
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      seen2 <= 1'b0;
      seen3 <= 1'b0;
    end else begin
      seen2 <= pin2;
      seen3 <= pin3;
    end
  end
endmodule // gpm_pin_sampler
`default_nettype wire

// ---- tb/test_gpm_top.sv ----
/*
  Self-checking bench for the two-pin function multiplexer.
  Assumes the slave answers each request within a few cycles and that
  the pins follow a committed control word one register later.
*/
`timescale 1ns/10ps
`default_nettype none

module test_gpm_top;
  import gpm_pkg::*;

  // ==========================================================
  // Signals
  // ==========================================================
  logic              clk = 1'b0;
  logic              resetn = 1'b0;
  logic [11:0]       awaddr, araddr;
  logic [31:0]       wdata, rdata, rd;
  logic [3:0]        wstrb;
  logic              awvalid, awready, wvalid, wready, bvalid;
  logic              arvalid, arready, rvalid, inv, ph, want;
  logic [1:0]        bresp, rresp, resp;
  logic [17:0]       one;
  gpm_sources_type   sources;
  logic              clkout2, clkout3, pin2, pin3, seen2, seen3;
  int                error_cnt = 0;
  int                comparisons = 0;
  int                cycles = 0;
  // Source bit per function code; 30 = clock or level, 31 = reserved.
  int route_row [32] = '{30, 30, 17, 16, 15, 31, 14, 13, 31, 12, 11, 10,
                         9, 8, 7, 6, 5, 4, 3, 2, 31, 1, 0, 31,
                         31, 31, 31, 31, 31, 31, 31, 31};

  always #2 clk = ~clk;

  gpm_top dut (
    .clk(clk), .resetn(resetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(1'b1), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(1'b1), .sources(sources),
    .pin2_clock_output(clkout2), .pin3_clock_output(clkout3),
    .pin2_out(pin2), .pin3_out(pin3));

  gpm_pin_sampler far_end (
    .clk(clk), .resetn(resetn), .pin2(pin2), .pin3(pin3),
    .seen2(seen2), .seen3(seen3));

  // ==========================================================
  // Compare, bus and closing tasks
  // ==========================================================
  task automatic check_pin(input logic got, input logic exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: pin %b, expected %b", $time, got, exp);
    end
  endtask

  task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: word %h, expected %h", $time, got, exp);
    end
  endtask

  task automatic results;
    $display("comparisons %0d, mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // Both tasks are entered just after a rising edge; bready and rready
  // stay high, so no strobe is ever lowered and raised in one step.
  task automatic axi_write(input logic [11:0] a, input logic [31:0] d,
                           input logic [3:0] st, output logic [1:0] r);
    awaddr  <= a;
    wdata   <= d;
    wstrb   <= st;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    do begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    r = bresp;
  endtask

  task automatic axi_read(input logic [11:0] a, output logic [31:0] d,
                          output logic [1:0] r);
    araddr  <= a;
    arvalid <= 1'b1;
    do begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
  endtask

  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      error_cnt++;
      results();
    end
  end

  // ==========================================================
  // Stimulus
  // ==========================================================
  initial begin
    awaddr = '0; araddr = '0; wdata = '0; wstrb = '0;
    awvalid = 1'b0; wvalid = 1'b0; arvalid = 1'b0;
    sources = '0; clkout2 = 1'b0; clkout3 = 1'b0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    // Each row is driven both ways so a wrong route cannot hide.
    for (int p = 0; p < 2; p++) begin
      for (int c = 0; c < 32; c++) begin
        for (int k = 0; k < 4; k++) begin
          inv = k[1];
          ph  = k[0];
          axi_write(p ? 12'h808 : 12'h804,
                    {21'h0, inv, 3'h0, ph, 1'h0, c[4:0]}, 4'h3, resp);
          check_word({30'h0, resp}, {30'h0, RESP_OKAY});
          one = 18'h1 << route_row[c];
          sources <= ph ? one : ~one;
          clkout2 <= ph ^ p[0];
          clkout3 <= ~(ph ^ p[0]);
          repeat (3) @(posedge clk);
          want = (route_row[c] == 31) ? inv : ph ^ inv;
          check_pin(p ? seen3 : seen2, want);
          check_pin(p ? pin3 : pin2, want);
          axi_read(p ? 12'h808 : 12'h804, rd, resp);
          check_word(rd & ~32'h40, {21'h0, inv, 5'h0, c[4:0]});
        end
      end
    end
    // Mid-run reset clears both control words and the pins.
    resetn <= 1'b0;
    clkout2 <= 1'b0;
    repeat (2) @(posedge clk);
    check_pin(pin2, 1'b0);
    check_pin(pin3, 1'b0);
    resetn <= 1'b1;
    @(posedge clk);
    axi_read(12'h804, rd, resp);
    check_word(rd, 32'h0);
    axi_read(12'h808, rd, resp);
    check_word(rd, 32'h0);
    // Byte lane 1 only: invert changes, selector keeps its value.
    axi_write(12'h804, 32'h0000_0402, 4'h2, resp);
    axi_read(12'h804, rd, resp);
    check_word(rd, 32'h0000_0400);
    // Unmapped accesses are refused and leave the map untouched.
    axi_write(12'h80c, 32'h0000_0001, 4'hf, resp);
    check_word({30'h0, resp}, {30'h0, RESP_SLVERR});
    axi_read(12'h800, rd, resp);
    check_word(rd, 32'h0);
    check_word({30'h0, resp}, {30'h0, RESP_SLVERR});
    axi_read(12'h804, rd, resp);
    check_word(rd, 32'h0000_0400);
    results();
  end
endmodule // test_gpm_top
`default_nettype wire
